// ==== ptx_defs.svh ====
// constants for the packet transmit port link and its two ends
`ifndef PTX_DEFS_SVH
`define PTX_DEFS_SVH

`define PTX_NUM_PORTS 4
`define PTX_WORD_W 16
`define PTX_ADDR_W 5
`define PTX_WM_W 8
`define PTX_FIFO_DEPTH 16
`define PTX_NULL_ADDR 5'h1f
`define PTX_BASE_ADDR 5'h00
`define PTX_ABORT_BYTE0 8'h7d
`define PTX_ABORT_BYTE1 8'h7e
// fifo entry layout: {abort, one_byte, eop, word}
`define PTX_ENT_W 19
`define PTX_ENT_EOP 16
`define PTX_ENT_ONE 17
`define PTX_ENT_ABT 18

`endif

// ==== ptx_pkg.sv ====
// types shared by the packet transmit port ends
package ptx_pkg;

    typedef enum logic [2:0] {
        PTX_IDLE = 3'b000,
        PTX_HI = 3'b001,
        PTX_LO = 3'b010,
        PTX_ABT0 = 3'b011,
        PTX_ABT1 = 3'b100
    } ptx_drain_type;

endpackage

// ==== ptx_link_if.sv ====
// pin bundle between the link-side writer and the packet transmit port
`timescale 1ns/1ps
`default_nettype none
`include "ptx_defs.svh"

interface ptx_link_if;
    logic [`PTX_WORD_W-1:0] tx_word_bus;
    logic tx_write_enable_n;
    logic [`PTX_ADDR_W-1:0] tx_port_select;
    logic tx_start_of_pkt;
    logic tx_end_of_pkt;
    logic tx_last_word_size;
    logic tx_abort_flag;
    logic [`PTX_NUM_PORTS-1:0] direct_tx_pkt_avail;

    modport dev (
        input tx_word_bus,
        input tx_write_enable_n,
        input tx_port_select,
        input tx_start_of_pkt,
        input tx_end_of_pkt,
        input tx_last_word_size,
        input tx_abort_flag,
        output direct_tx_pkt_avail
    );

    modport host (
        output tx_word_bus,
        output tx_write_enable_n,
        output tx_port_select,
        output tx_start_of_pkt,
        output tx_end_of_pkt,
        output tx_last_word_size,
        output tx_abort_flag,
        input direct_tx_pkt_avail
    );
endinterface

`default_nettype wire

// ==== ptx_device.sv ====
// packet transmit port: per-port fifos, availability flags, drain with abort
//
// Summary of operation
// [RL1] one availability output per port, four ports
// [RL2] raise availability at low water-mark free room
// [RL3] drop availability at high water-mark near full
// [RL4] availability outputs change only on clock edges
// [RL5] word size only meaningful with end flag
// [RL6] writer sends full words except the last
// [RL7] size high keeps upper byte only
// [RL8] end, size, abort valid only when written here
// [RL9] end, size, abort sampled on rising clock
// [RL10] end flag marks the packet's final word
// [RL11] start and end in one word allowed
// [RL12] writer raises abort only on last word
// [RL13] aborted packet gets 7d 7e appended
// [RL14] null or foreign address means not selected
// [RL15] size and abort ignored without end flag
`timescale 1ns/1ps
`default_nettype none
`include "ptx_defs.svh"

// ----------------------------------------------------------------
// flip-flop fifo
// ----------------------------------------------------------------
module ptx_fifo #(
    parameter int WIDTH = `PTX_ENT_W,
    parameter int DEPTH = `PTX_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // fill side
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    // drain side
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data,
    // occupancy
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("ptx_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [$clog2(DEPTH+1)-1:0] cnt_r;
    logic push;
    logic pop;

    assign s_ready = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign m_valid = (cnt_r != '0);
    assign m_data = mem_r[rd_ptr_r];
    assign level = cnt_r;
    assign push = s_valid && s_ready;
    assign pop = m_valid && m_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= s_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------------------------------
// device end
// ----------------------------------------------------------------
module ptx_device
    import ptx_pkg::*;
#(
    parameter logic [`PTX_ADDR_W-1:0] BASE_ADDR = `PTX_BASE_ADDR,
    parameter int NUM_PORTS = `PTX_NUM_PORTS,
    parameter int DEPTH = `PTX_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link pins
    ptx_link_if.dev lnk,
    // water-marks, in free fifo words
    input wire logic [`PTX_WM_W-1:0] avail_low_watermark,
    input wire logic [`PTX_WM_W-1:0] avail_high_watermark,
    // outgoing byte stream
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_byte,
    output logic [1:0] out_port,
    output logic out_last
);
    localparam int LW = $clog2(DEPTH+1);

    if (NUM_PORTS != `PTX_NUM_PORTS) begin : g_bad_ports
        $error("ptx_device serves exactly four ports");
    end
    if (int'(BASE_ADDR) + NUM_PORTS > int'(`PTX_NULL_ADDR)) begin : g_bad_base
        $error("ptx_device address range overlaps the null address");
    end
    if (DEPTH > 255) begin : g_bad_room
        $error("ptx_device free-word count is eight bits wide");
    end

    // ------------------------------------------------------------
    // address decode and write qualification
    // ------------------------------------------------------------
    logic [`PTX_ADDR_W:0] addr_ext;
    logic [`PTX_ADDR_W:0] addr_off;
    logic selected;
    logic wr_ok;
    logic [`PTX_ENT_W-1:0] entry;

    assign addr_ext = {1'b0, lnk.tx_port_select};
    assign addr_off = addr_ext - {1'b0, BASE_ADDR};
    assign selected = (lnk.tx_port_select != `PTX_NULL_ADDR) &&
                      (lnk.tx_port_select >= BASE_ADDR) &&
                      (addr_off < 6'(NUM_PORTS)); // RL14
    assign wr_ok = !lnk.tx_write_enable_n && selected; // RL8
    // size and abort only stored alongside an end flag
    assign entry = {lnk.tx_abort_flag && lnk.tx_end_of_pkt, // RL15
                    lnk.tx_last_word_size && lnk.tx_end_of_pkt, // RL5
                    lnk.tx_end_of_pkt, // RL10 RL11
                    lnk.tx_word_bus};

    // ------------------------------------------------------------
    // per-port fifos and availability flags
    // ------------------------------------------------------------
    // nets: each bit or entry has its own driver in the port loop; f_pop is a variable set in the drain logic
    wire logic [NUM_PORTS-1:0] f_valid;
    logic [NUM_PORTS-1:0] f_pop;
    wire logic [`PTX_ENT_W-1:0] f_head [NUM_PORTS];
    wire logic [NUM_PORTS-1:0] avail_all;

    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        logic [LW-1:0] lvl;
        logic [`PTX_WM_W-1:0] free_w;
        logic flag_r;

        ptx_fifo #(
            .WIDTH(`PTX_ENT_W),
            .DEPTH(DEPTH)
        ) u_fifo (
            .clk(clk),
            .nrst(nrst),
            .s_valid(wr_ok && (addr_off == 6'(i))), // RL9
            .s_ready(),
            .s_data(entry),
            .m_valid(f_valid[i]),
            .m_ready(f_pop[i]),
            .m_data(f_head[i]),
            .level(lvl)
        );

        assign free_w = `PTX_WM_W'(DEPTH) - `PTX_WM_W'(lvl);

        // falling test first: overrun protection beats hysteresis
        always_ff @(posedge clk) begin
            if (!nrst) begin
                flag_r <= 1'b0;
            end else if (free_w <= avail_high_watermark) begin
                flag_r <= 1'b0; // RL3
            end else if (free_w >= avail_low_watermark) begin
                flag_r <= 1'b1; // RL2
            end
        end

        assign avail_all[i] = flag_r;
    end

    assign lnk.direct_tx_pkt_avail = avail_all; // RL1 RL4

    // ------------------------------------------------------------
    // drain: one packet at a time, ports taken in rotation
    // ------------------------------------------------------------
    ptx_drain_type state_r;
    logic [1:0] cur_r;
    logic [1:0] next_port;
    logic found;
    logic [`PTX_ENT_W-1:0] head;
    logic slot_free;
    logic out_valid_r;
    logic [7:0] out_byte_r;
    logic [1:0] out_port_r;
    logic out_last_r;

    assign head = f_head[cur_r];
    assign slot_free = !out_valid_r || out_ready;

    // rotating search from the port after the last one served
    always_comb begin
        logic [1:0] cand;
        cand = '0;
        next_port = cur_r;
        found = 1'b0;
        for (int k = 1; k <= NUM_PORTS; k++) begin
            cand = cur_r + 2'(k);
            if (!found && f_valid[cand]) begin
                next_port = cand;
                found = 1'b1;
            end
        end
    end

    always_comb begin
        f_pop = '0;
        if (slot_free && f_valid[cur_r]) begin
            if (state_r == PTX_LO ||
                (state_r == PTX_HI && head[`PTX_ENT_EOP] && head[`PTX_ENT_ONE])) begin
                f_pop[cur_r] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= PTX_IDLE;
            cur_r <= '0;
        end else begin
            case (state_r)
                PTX_IDLE: begin
                    if (found) begin
                        cur_r <= next_port;
                        state_r <= PTX_HI;
                    end
                end
                PTX_HI: begin
                    if (slot_free && f_valid[cur_r]) begin
                        if (head[`PTX_ENT_EOP] && head[`PTX_ENT_ONE]) begin
                            state_r <= head[`PTX_ENT_ABT] ? PTX_ABT0 : PTX_IDLE; // RL7
                        end else begin
                            state_r <= PTX_LO;
                        end
                    end
                end
                PTX_LO: begin
                    if (slot_free && f_valid[cur_r]) begin
                        if (head[`PTX_ENT_EOP]) begin
                            state_r <= head[`PTX_ENT_ABT] ? PTX_ABT0 : PTX_IDLE; // RL13
                        end else begin
                            state_r <= PTX_HI;
                        end
                    end
                end
                PTX_ABT0: begin
                    if (slot_free) begin
                        state_r <= PTX_ABT1;
                    end
                end
                PTX_ABT1: begin
                    if (slot_free) begin
                        state_r <= PTX_IDLE;
                    end
                end
                default: begin
                    state_r <= PTX_IDLE;
                end
            endcase
        end
    end

    // output byte register, held until taken
    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_valid_r <= 1'b0;
            out_byte_r <= '0;
            out_port_r <= '0;
            out_last_r <= 1'b0;
        end else if (slot_free) begin
            out_valid_r <= 1'b0;
            out_port_r <= cur_r;
            if ((state_r == PTX_HI || state_r == PTX_LO) && f_valid[cur_r]) begin
                out_valid_r <= 1'b1;
                out_byte_r <= (state_r == PTX_HI) ? head[15:8] : head[7:0];
                out_last_r <= head[`PTX_ENT_EOP] && !head[`PTX_ENT_ABT] &&
                              (state_r == PTX_LO || head[`PTX_ENT_ONE]);
            end else if (state_r == PTX_ABT0) begin
                out_valid_r <= 1'b1;
                out_byte_r <= `PTX_ABORT_BYTE0; // RL13
                out_last_r <= 1'b0;
            end else if (state_r == PTX_ABT1) begin
                out_valid_r <= 1'b1;
                out_byte_r <= `PTX_ABORT_BYTE1; // RL13
                out_last_r <= 1'b1;
            end
        end
    end

    assign out_valid = out_valid_r;
    assign out_byte = out_byte_r;
    assign out_port = out_port_r;
    assign out_last = out_last_r;
endmodule

`default_nettype wire

// ==== ptx_host.sv ====
// link-side writer: takes packet words from the user and writes them to the port
`timescale 1ns/1ps
`default_nettype none
`include "ptx_defs.svh"

module ptx_host
    import ptx_pkg::*;
#(
    parameter logic [`PTX_ADDR_W-1:0] BASE_ADDR = `PTX_BASE_ADDR
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link pins
    ptx_link_if.host lnk,
    // user word request
    input wire logic usr_valid,
    output logic usr_ready,
    input wire logic [1:0] usr_port,
    input wire logic [`PTX_WORD_W-1:0] usr_word,
    input wire logic usr_sop,
    input wire logic usr_eop,
    input wire logic usr_one_byte,
    input wire logic usr_abort
);
    if (int'(BASE_ADDR) + `PTX_NUM_PORTS > int'(`PTX_NULL_ADDR)) begin : g_bad_base
        $error("ptx_host address range overlaps the null address");
    end

    // ------------------------------------------------------------
    // one pending word, written once its port shows room
    // ------------------------------------------------------------
    logic pend_r;
    logic [1:0] p_port_r;
    logic [`PTX_WORD_W-1:0] p_word_r;
    logic p_sop_r;
    logic p_eop_r;
    logic p_one_r;
    logic p_abt_r;
    logic ready_r;
    logic accept;
    logic issue;
    logic pend_nxt;

    assign accept = usr_valid && ready_r;
    assign issue = pend_r && lnk.direct_tx_pkt_avail[p_port_r];
    assign pend_nxt = (pend_r && !issue) || accept;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pend_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            ready_r <= !pend_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            p_port_r <= '0;
            p_word_r <= '0;
            p_sop_r <= 1'b0;
            p_eop_r <= 1'b0;
            p_one_r <= 1'b0;
            p_abt_r <= 1'b0;
        end else if (accept) begin
            p_port_r <= usr_port;
            p_word_r <= usr_word;
            p_sop_r <= usr_sop;
            p_eop_r <= usr_eop; // RL10
            p_one_r <= usr_one_byte && usr_eop; // RL5 RL6
            p_abt_r <= usr_abort && usr_eop; // RL12
        end
    end

    // ------------------------------------------------------------
    // pin registers; idle parks on the null address
    // ------------------------------------------------------------
    logic en_n_r;
    logic [`PTX_ADDR_W-1:0] addr_r;
    logic [`PTX_WORD_W-1:0] word_r;
    logic sop_r;
    logic eop_r;
    logic size_r;
    logic abt_r;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            en_n_r <= 1'b1;
            addr_r <= `PTX_NULL_ADDR;
            word_r <= '0;
            sop_r <= 1'b0;
            eop_r <= 1'b0;
            size_r <= 1'b0;
            abt_r <= 1'b0;
        end else if (issue) begin
            en_n_r <= 1'b0;
            addr_r <= BASE_ADDR + `PTX_ADDR_W'(p_port_r);
            word_r <= p_word_r;
            sop_r <= p_sop_r;
            eop_r <= p_eop_r;
            size_r <= p_one_r; // RL7
            abt_r <= p_abt_r;
        end else begin
            en_n_r <= 1'b1;
            addr_r <= `PTX_NULL_ADDR;
            sop_r <= 1'b0;
            eop_r <= 1'b0;
            size_r <= 1'b0;
            abt_r <= 1'b0;
        end
    end

    assign usr_ready = ready_r;
    assign lnk.tx_write_enable_n = en_n_r;
    assign lnk.tx_port_select = addr_r;
    assign lnk.tx_word_bus = word_r;
    assign lnk.tx_start_of_pkt = sop_r;
    assign lnk.tx_end_of_pkt = eop_r;
    assign lnk.tx_last_word_size = size_r;
    assign lnk.tx_abort_flag = abt_r;
endmodule

`default_nettype wire

// ==== ptx_link_props.sv ====
// concurrent checks on the packet transmit link pins
`timescale 1ns/1ps
`default_nettype none
`include "ptx_defs.svh"

module ptx_link_props (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link pins
    input wire logic [`PTX_WORD_W-1:0] tx_word_bus,
    input wire logic tx_write_enable_n,
    input wire logic [`PTX_ADDR_W-1:0] tx_port_select,
    input wire logic tx_start_of_pkt,
    input wire logic tx_end_of_pkt,
    input wire logic tx_last_word_size,
    input wire logic tx_abort_flag,
    input wire logic [`PTX_NUM_PORTS-1:0] direct_tx_pkt_avail
);
    // ----------------------------------------
    // history of writes and flags
    // ----------------------------------------
    logic [3:0] avail_q_r;
    logic [3:0] hit1_r;
    logic [3:0] hit2_r;
    logic [3:0] hit3_r;
    logic [3:0] hit_nxt;

    assign hit_nxt = tx_write_enable_n ? 4'h0 : (4'h1 << tx_port_select[1:0]);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            avail_q_r <= 4'h0;
            hit1_r <= 4'h0;
            hit2_r <= 4'h0;
            hit3_r <= 4'h0;
        end else begin
            avail_q_r <= direct_tx_pkt_avail;
            hit1_r <= hit_nxt;
            hit2_r <= hit1_r;
            hit3_r <= hit2_r;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    idle_select_a: assert property (tx_write_enable_n |-> tx_port_select == `PTX_NULL_ADDR)
        else $error("idle select not null");
    write_select_a: assert property (!tx_write_enable_n |-> (tx_port_select - `PTX_BASE_ADDR) < 5'h04)
        else $error("write to unmapped select");
    quiet_flags_a: assert property (tx_write_enable_n |-> !(tx_start_of_pkt || tx_end_of_pkt
        || tx_last_word_size || tx_abort_flag))
        else $error("qualifier high without write");
    write_gap_a: assert property ($fell(tx_write_enable_n) |=> $rose(tx_write_enable_n))
        else $error("writes closer than two cycles");
    abort_last_a: assert property (tx_abort_flag |-> tx_end_of_pkt)
        else $error("abort on non-final word");
    size_last_a: assert property (tx_last_word_size |-> tx_end_of_pkt)
        else $error("size flag on non-final word");
    write_room_a: assert property (!tx_write_enable_n |-> avail_q_r[tx_port_select[1:0]])
        else $error("write to port without room");
    drop_cause_a: assert property ((avail_q_r & ~direct_tx_pkt_avail & ~(hit1_r | hit2_r | hit3_r)) == 4'h0)
        else $error("flag fell without a write");

    cover property (!tx_write_enable_n && tx_end_of_pkt && tx_last_word_size && tx_word_bus != 16'h0000);
    cover property (!tx_write_enable_n && tx_abort_flag);
    cover property ((avail_q_r & ~direct_tx_pkt_avail) != 4'h0);
endmodule

`default_nettype wire

// ==== packet_tx_port_flow_and_eop_tb.sv ====
// self-checking bench joining the link writer and the transmit port
`timescale 1ns/1ps
`default_nettype none
`include "ptx_defs.svh"

module packet_tx_port_flow_and_eop_tb
    import ptx_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic usr_valid = 1'b0;
    logic usr_ready;
    logic [1:0] usr_port = 2'h0;
    logic [15:0] usr_word = 16'h0000;
    logic usr_sop = 1'b0;
    logic usr_eop = 1'b0;
    logic usr_one_byte = 1'b0;
    logic usr_abort = 1'b0;
    logic out_valid;
    logic out_ready = 1'b1;
    logic [7:0] out_byte;
    logic [1:0] out_port;
    logic out_last;
    logic [7:0] low_wm = 8'h08;
    logic [7:0] high_wm = 8'h04;
    logic [3:0] avail;
    int error_cnt = 0;
    int tests_run = 0;
    logic [10:0] exp_q[$];
    logic [10:0] got_q[$];

    always #5 clk = ~clk;

    // ----------------------------------------
    // the two ends and the checker
    // ----------------------------------------
    ptx_link_if i_ptx_link_if ();
    assign avail = i_ptx_link_if.direct_tx_pkt_avail;

    ptx_host i_ptx_host (.clk(clk), .nrst(nrst), .lnk(i_ptx_link_if.host), .usr_valid(usr_valid),
        .usr_ready(usr_ready), .usr_port(usr_port), .usr_word(usr_word), .usr_sop(usr_sop),
        .usr_eop(usr_eop), .usr_one_byte(usr_one_byte), .usr_abort(usr_abort));

    ptx_device i_ptx_device (.clk(clk), .nrst(nrst), .lnk(i_ptx_link_if.dev),
        .avail_low_watermark(low_wm), .avail_high_watermark(high_wm), .out_valid(out_valid),
        .out_ready(out_ready), .out_byte(out_byte), .out_port(out_port), .out_last(out_last));

    ptx_link_props i_ptx_link_props (.clk(clk), .nrst(nrst),
        .tx_word_bus(i_ptx_link_if.tx_word_bus), .tx_write_enable_n(i_ptx_link_if.tx_write_enable_n),
        .tx_port_select(i_ptx_link_if.tx_port_select), .tx_start_of_pkt(i_ptx_link_if.tx_start_of_pkt),
        .tx_end_of_pkt(i_ptx_link_if.tx_end_of_pkt), .tx_last_word_size(i_ptx_link_if.tx_last_word_size),
        .tx_abort_flag(i_ptx_link_if.tx_abort_flag), .direct_tx_pkt_avail(avail));

    // bytes are logged as taken, so stalls never hide a lost byte
    always @(posedge clk) begin
        if (nrst === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
            got_q.push_back({out_port, out_last, out_byte});
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic expb(input logic [1:0] p, input logic [7:0] b, input logic l);
        exp_q.push_back({p, l, b});
    endtask

    // request held until taken; ok low means the writer stayed busy
    task automatic send(input logic [1:0] p, input logic [15:0] w, input logic s, input logic e,
                        input logic one, input logic abt, output bit ok);
        int n;
        @(negedge clk);
        usr_valid = 1'b1;
        usr_port = p;
        usr_word = w;
        usr_sop = s;
        usr_eop = e;
        usr_one_byte = one;
        usr_abort = abt;
        n = 0;
        while (usr_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        ok = (usr_ready === 1'b1);
        if (ok) begin
            @(negedge clk);
            usr_valid = 1'b0;
        end
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (got_q.size() < exp_q.size() && n < 400) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
        chk("byte count", 16'(got_q.size()), 16'(exp_q.size()));
        for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
            chk("byte", 16'(got_q[i]), 16'(exp_q[i]));
        end
        exp_q.delete();
        got_q.delete();
        chk("avail after drain", {12'h000, avail}, 16'h000f);
    endtask

    // size and abort ride on every word; only the final word may honour them
    task automatic pkt(input logic [1:0] p, input int n, input logic one, input logic abt);
        bit ok;
        logic [15:0] w;
        for (int i = 0; i < n; i++) begin
            w = {4'ha, 2'h0, p, 4'h5, i[3:0]};
            send(p, w, i == 0, i == n - 1, one, abt, ok);
            chk("accept", {15'h0000, ok}, 16'h0001);
            expb(p, w[15:8], i == n - 1 && one && !abt);
            if (i < n - 1 || !one) expb(p, w[7:0], i == n - 1 && !abt);
        end
        if (abt) begin
            expb(p, `PTX_ABORT_BYTE0, 1'b0);
            expb(p, `PTX_ABORT_BYTE1, 1'b1);
        end
        drain();
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic sc_basic();
        pkt(2'd0, 3, 1'b1, 1'b0);
        pkt(2'd1, 4, 1'b0, 1'b0);
    endtask

    task automatic sc_ports();
        for (int p = 0; p < 4; p++) begin
            pkt(p[1:0], 1, p[0], 1'b0);
        end
    endtask

    task automatic sc_abort();
        pkt(2'd2, 2, 1'b0, 1'b1);
        pkt(2'd3, 1, 1'b1, 1'b1);
    endtask

    // stalled sink: port one fills until its flag drops, the others stay up
    task automatic sc_fill();
        bit ok;
        int n;
        @(negedge clk);
        out_ready = 1'b0;
        ok = 1'b1;
        n = 0;
        while (ok && n < 16) begin
            send(2'd1, {8'hc0, n[7:0]}, n == 0, 1'b0, 1'b0, 1'b0, ok);
            if (ok) begin
                expb(2'd1, 8'hc0, 1'b0);
                expb(2'd1, n[7:0], 1'b0);
                n++;
            end
        end
        chk("avail when full", {12'h000, avail}, 16'h000d);
        chk("fill depth", {15'h0000, n >= 12 && n <= 15}, 16'h0001);
        @(negedge clk);
        out_ready = 1'b1;
        send(2'd1, {8'hc0, n[7:0]}, 1'b0, 1'b0, 1'b0, 1'b0, ok);
        expb(2'd1, 8'hc0, 1'b0);
        expb(2'd1, n[7:0], 1'b0);
        send(2'd1, 16'hee11, 1'b0, 1'b1, 1'b1, 1'b0, ok);
        expb(2'd1, 8'hee, 1'b1);
        drain();
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (5) @(negedge clk);
        chk("avail in reset", {12'h000, avail}, 16'h0000);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        chk("avail after reset", {12'h000, avail}, 16'h000f);
        sc_basic();
        sc_ports();
        sc_abort();
        sc_fill();
        complete_run();
    end

    initial begin
        #200000;
        error_cnt++;
        $display("BAD watchdog exp done seen hang");
        complete_run();
    end
endmodule

`default_nettype wire
